// >>> fifo_pkg.sv
// Shared constants, field layout and helpers of the embedded dual-port FIFO.
// Function
// - A 3-bit code picks 4kx1, 2kx2, 1kx4, 512x9 or 256x18; 101-111 reserved.
// - Active-low block selects enable ports; deselected read port holds data.
// - Write enable active low, read enable active high; both polarities settable.
// - Writes follow the write clock, reads the read clock; one driver allowed; here both ports run on the single clock input.
// - Pipeline select low: data after the read edge; high: one cycle later.
// - Reset clears counters, zeroes read data, lowers full flags, raises empty.
// - Read bus is 18 bits; bits above the read width are meaningless.
// - Empty stop high freezes the read counter once empty is high.
// - Full stop high freezes the write counter once full is high.
// - Counters run from zero to the top of their 13 bits and then wrap.
// - Full rises with the write clock and falls two edges after a read.
// - Empty rises with the read clock and falls two edges after a write.
// - Separate 13-bit write and read counters advance on each transfer.
// - Almost-full is high while write minus read reaches its threshold.
// - Almost-empty is high while write minus read is at most its threshold.
// - Full or empty rises once one whole word cannot be written or read.
package fifo_pkg;

  localparam int ADDR_W   = 12;
  localparam int PTR_W    = 13;
  localparam int DATA_W   = 18;
  localparam int CODE_W   = 3;
  localparam int BITS_N   = 4096;
  localparam int EXTRA_N  = 512;
  localparam int APB_A_W  = 8;

  localparam logic [CODE_W-1:0] CODE_X1  = 3'h0;
  localparam logic [CODE_W-1:0] CODE_X2  = 3'h1;
  localparam logic [CODE_W-1:0] CODE_X4  = 3'h2;
  localparam logic [CODE_W-1:0] CODE_X9  = 3'h3;
  localparam logic [CODE_W-1:0] CODE_X18 = 3'h4;

  localparam logic [PTR_W:0]    CAPACITY   = 14'h1000;
  localparam logic [ADDR_W-1:0] BYTE_STEP  = 12'h008;
  localparam logic [8:0]        EXTRA_STEP = 9'h001;

  // Register offsets (byte addresses on the APB).
  localparam logic [APB_A_W-1:0] CONFIG_OFFSET = 8'h00;
  localparam logic [APB_A_W-1:0] THRESH_OFFSET = 8'h04;
  localparam logic [APB_A_W-1:0] STATUS_OFFSET = 8'h08;

  // Configuration field positions and reset values.
  localparam int CFG_WCODE_LSB = 0;
  localparam int CFG_RCODE_LSB = 3;
  localparam int CFG_WEN_HIGH  = 6;
  localparam int CFG_REN_HIGH  = 7;
  localparam int CFG_PIPE      = 8;
  localparam int CFG_EMPTY_STOP     = 9;
  localparam int CFG_FULL_STOP     = 10;
  localparam int THR_AF_LSB    = 0;
  localparam int THR_AE_LSB    = 16;
  localparam int ST_WPTR_LSB   = 4;
  localparam int ST_RPTR_LSB   = 16;
  localparam logic [ADDR_W-1:0] AF_RESET = 12'hFFF;
  localparam logic [ADDR_W-1:0] AE_RESET = 12'h000;

  // Main-array bits that one word of the given code moves (9th bits excluded); zero marks a reserved code.
  function automatic logic [PTR_W-1:0] stepBits(input logic [CODE_W-1:0] c);
    case (c)
      CODE_X1:  stepBits = 13'h0001;
      CODE_X2:  stepBits = 13'h0002;
      CODE_X4:  stepBits = 13'h0004;
      CODE_X9:  stepBits = 13'h0008;
      CODE_X18: stepBits = 13'h0010;
      default:  stepBits = 13'h0000;
    endcase
  endfunction

  function automatic logic [PTR_W-1:0] toGray(input logic [PTR_W-1:0] b);
    toGray = b ^ (b >> 1);
  endfunction

  function automatic logic [PTR_W-1:0] fromGray(input logic [PTR_W-1:0] g);
    logic [PTR_W-1:0] b;
    b[PTR_W-1] = g[PTR_W-1];
    for (int i = PTR_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    fromGray = b;
  endfunction

endpackage

// >>> pointer_sync.sv
// Two-stage synchroniser for a gray-coded counter.
`timescale 1ns/1ps
module pointer_sync #(
  parameter int WIDTH = 13
) (
  input  wire logic             clock,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } sync_type;

  sync_type state_reg;
  sync_type state_next;

  // The first stage feeds only the second stage.
  always_comb begin
    state_next.first  = din;
    state_next.second = state_reg.first;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign dout = state_reg.second;

endmodule

// >>> dual_clock_embedded_fifo.sv
// Embedded 4,608-bit FIFO with selectable port widths and an APB config port.
`timescale 1ns/1ps
module dual_clock_embedded_fifo (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        fifoResetN,
  input  wire logic        writeBlockSelectN,
  input  wire logic        writeEnable,
  input  wire logic [17:0] writeData,
  input  wire logic        readBlockSelectN,
  input  wire logic        readEnable,
  output logic      [17:0] readData,
  output logic             full,
  output logic             empty,
  output logic             almostFullFlag,
  output logic             almostEmptyFlag
);

  typedef struct packed {
    logic [fifo_pkg::BITS_N-1:0]  bits;
    logic [fifo_pkg::EXTRA_N-1:0] extra;
    logic [fifo_pkg::PTR_W-1:0]   wrPtr;
    logic [fifo_pkg::PTR_W-1:0]   rdPtr;
    logic [fifo_pkg::PTR_W-1:0]   wrGray;
    logic [fifo_pkg::PTR_W-1:0]   rdGray;
    logic [fifo_pkg::DATA_W-1:0]  stage1;
    logic [fifo_pkg::DATA_W-1:0]  stage2;
    logic [fifo_pkg::CODE_W-1:0]  writeWidthCode;
    logic [fifo_pkg::CODE_W-1:0]  readWidthCode;
    logic                         wenHigh;
    logic                         renHigh;
    logic                         readPipelineSelect;
    logic                         emptyStop;
    logic                         fullStop;
    logic [fifo_pkg::ADDR_W-1:0]  almostFullThreshold;
    logic [fifo_pkg::ADDR_W-1:0]  almostEmptyThreshold;
    logic [31:0]                  readBack;
  } state_type;

  state_type state_reg;
  state_type state_next;

  logic [fifo_pkg::PTR_W-1:0]  wrGraySync;
  logic [fifo_pkg::PTR_W-1:0]  rdGraySync;
  logic [fifo_pkg::PTR_W-1:0]  wrSyncBin;
  logic [fifo_pkg::PTR_W-1:0]  rdSyncBin;
  logic [fifo_pkg::PTR_W-1:0]  writeStep;
  logic [fifo_pkg::PTR_W-1:0]  readStep;
  logic [fifo_pkg::PTR_W-1:0]  fillWrite;
  logic [fifo_pkg::PTR_W-1:0]  fillRead;
  logic [fifo_pkg::DATA_W-1:0] readWordNow;
  logic                        wenActive;
  logic                        renActive;
  logic                        writeAccept;
  logic                        readAccept;
  logic                        apbWrite;
  logic                        apbSetupRead;
  logic                        mapped;
  logic [31:0]                 statusWord;

  // Each side sees the other's counter only through two flops, which is
  // what keeps full and empty asserted for two edges after they clear.
  pointer_sync #(
    .WIDTH (fifo_pkg::PTR_W)
  ) wrSyncInst (
    .clock (clock),
    .nrst  (nrst),
    .din   (state_reg.wrGray),
    .dout  (wrGraySync)
  );

  pointer_sync #(
    .WIDTH (fifo_pkg::PTR_W)
  ) rdSyncInst (
    .clock (clock),
    .nrst  (nrst),
    .din   (state_reg.rdGray),
    .dout  (rdGraySync)
  );

  // Picks one word at a bit address; 9th bits live in the side array.
  function automatic logic [fifo_pkg::DATA_W-1:0] readWord(
    input logic [fifo_pkg::BITS_N-1:0]  b,
    input logic [fifo_pkg::EXTRA_N-1:0] e,
    input logic [fifo_pkg::ADDR_W-1:0]  a,
    input logic [fifo_pkg::CODE_W-1:0]  c
  );
    logic [fifo_pkg::DATA_W-1:0] d;
    logic [8:0]                  ix;
    d  = '0;
    ix = a[11:3];
    case (c)
      fifo_pkg::CODE_X1:  d[0] = b[a];
      fifo_pkg::CODE_X2:  d[1:0] = b[a +: 2];
      fifo_pkg::CODE_X4:  d[3:0] = b[a +: 4];
      fifo_pkg::CODE_X9:  d[8:0] = {e[ix], b[a +: 8]};
      fifo_pkg::CODE_X18: d = {e[ix + fifo_pkg::EXTRA_STEP],
                               b[a + fifo_pkg::BYTE_STEP +: 8],
                               e[ix], b[a +: 8]};
      default:            d = '0;
    endcase
    readWord = d;
  endfunction

  // Port qualification: polarity, block select and the stop controls.
  always_comb begin
    writeStep = fifo_pkg::stepBits(state_reg.writeWidthCode);
    readStep  = fifo_pkg::stepBits(state_reg.readWidthCode);
    wenActive = state_reg.wenHigh ? writeEnable : !writeEnable;
    renActive = state_reg.renHigh ? readEnable : !readEnable;
    wrSyncBin = fifo_pkg::fromGray(wrGraySync);
    rdSyncBin = fifo_pkg::fromGray(rdGraySync);
    fillWrite = state_reg.wrPtr - rdSyncBin;
    fillRead  = wrSyncBin - state_reg.rdPtr;
    writeAccept = fifoResetN && !writeBlockSelectN && wenActive
                  && (writeStep != '0)
                  && !(full && state_reg.fullStop);
    readAccept  = fifoResetN && !readBlockSelectN && renActive
                  && (readStep != '0)
                  && !(empty && state_reg.emptyStop);
    readWordNow = readWord(state_reg.bits, state_reg.extra,
                           state_reg.rdPtr[fifo_pkg::ADDR_W-1:0],
                           state_reg.readWidthCode);
  end

  // Flags come straight from the counters so that a full or empty state
  // with its stop control set blocks the very next request; a whole word must fit or be present.
  always_comb begin
    full = fifoResetN && ((writeStep == '0)
           || ({1'b0, fillWrite} + {1'b0, writeStep}
               > fifo_pkg::CAPACITY));
    empty = !fifoResetN || (readStep == '0)
            || (fillRead < readStep);
    almostFullFlag = fifoResetN
                     && (fillWrite >= {1'b0, state_reg.almostFullThreshold});
    almostEmptyFlag = !fifoResetN
                      || (fillRead <= {1'b0, state_reg.almostEmptyThreshold});
    readData = !fifoResetN ? '0
               : (state_reg.readPipelineSelect ? state_reg.stage2
                                               : state_reg.stage1);
  end

  // The APB answers in the first access cycle; read data is caught at setup.
  always_comb begin
    mapped = (paddr == fifo_pkg::CONFIG_OFFSET)
             || (paddr == fifo_pkg::THRESH_OFFSET)
             || (paddr == fifo_pkg::STATUS_OFFSET);
    apbWrite     = psel && penable && pwrite && mapped;
    apbSetupRead = psel && !penable && !pwrite;
    pready       = 1'b1;
    pslverr      = psel && penable && !mapped;
    prdata       = state_reg.readBack;
    statusWord   = '0;
    statusWord[0] = full;
    statusWord[1] = empty;
    statusWord[2] = almostFullFlag;
    statusWord[3] = almostEmptyFlag;
    statusWord[fifo_pkg::ST_WPTR_LSB +: fifo_pkg::ADDR_W] =
      state_reg.wrPtr[fifo_pkg::ADDR_W-1:0];
    statusWord[fifo_pkg::ST_RPTR_LSB +: fifo_pkg::ADDR_W] =
      state_reg.rdPtr[fifo_pkg::ADDR_W-1:0];
  end

  // Next state: storage, counters, read stages and configuration.
  always_comb begin
    logic [fifo_pkg::ADDR_W-1:0] wa;
    logic [8:0]                  wx;
    state_next = state_reg;
    wa = state_reg.wrPtr[fifo_pkg::ADDR_W-1:0];
    wx = wa[11:3];
    // Writes land at the bit address of the write counter.
    if (writeAccept) begin
      case (state_reg.writeWidthCode)
        fifo_pkg::CODE_X1:  state_next.bits[wa] = writeData[0];
        fifo_pkg::CODE_X2:  state_next.bits[wa +: 2] = writeData[1:0];
        fifo_pkg::CODE_X4:  state_next.bits[wa +: 4] = writeData[3:0];
        fifo_pkg::CODE_X9: begin
          state_next.bits[wa +: 8] = writeData[7:0];
          state_next.extra[wx]     = writeData[8];
        end
        fifo_pkg::CODE_X18: begin
          state_next.bits[wa +: 8] = writeData[7:0];
          state_next.extra[wx]     = writeData[8];
          state_next.bits[wa + fifo_pkg::BYTE_STEP +: 8] = writeData[16:9];
          state_next.extra[wx + fifo_pkg::EXTRA_STEP]    = writeData[17];
        end
        default: state_next.bits = state_reg.bits;
      endcase
      // The low 12 bits wrap at the top of the array.
      state_next.wrPtr = state_reg.wrPtr + writeStep;
    end
    // A read loads the first stage; the second follows while selected.
    if (readAccept) begin
      state_next.stage1 = readWordNow;
      state_next.rdPtr  = state_reg.rdPtr + readStep;
    end
    if (!readBlockSelectN) begin
      state_next.stage2 = state_reg.stage1;
    end
    // Clearing the FIFO empties it without touching the stored bits.
    if (!fifoResetN) begin
      state_next.wrPtr  = '0;
      state_next.rdPtr  = '0;
      state_next.stage1 = '0;
      state_next.stage2 = '0;
    end
    state_next.wrGray = fifo_pkg::toGray(state_next.wrPtr);
    state_next.rdGray = fifo_pkg::toGray(state_next.rdPtr);
    // Software writes to the configuration and threshold words.
    if (apbWrite && (paddr == fifo_pkg::CONFIG_OFFSET)) begin
      state_next.writeWidthCode =
        pwdata[fifo_pkg::CFG_WCODE_LSB +: fifo_pkg::CODE_W];
      state_next.readWidthCode =
        pwdata[fifo_pkg::CFG_RCODE_LSB +: fifo_pkg::CODE_W];
      state_next.wenHigh            = pwdata[fifo_pkg::CFG_WEN_HIGH];
      state_next.renHigh            = pwdata[fifo_pkg::CFG_REN_HIGH];
      state_next.readPipelineSelect = pwdata[fifo_pkg::CFG_PIPE];
      state_next.emptyStop          = pwdata[fifo_pkg::CFG_EMPTY_STOP];
      state_next.fullStop           = pwdata[fifo_pkg::CFG_FULL_STOP];
    end
    if (apbWrite && (paddr == fifo_pkg::THRESH_OFFSET)) begin
      state_next.almostFullThreshold =
        pwdata[fifo_pkg::THR_AF_LSB +: fifo_pkg::ADDR_W];
      state_next.almostEmptyThreshold =
        pwdata[fifo_pkg::THR_AE_LSB +: fifo_pkg::ADDR_W];
    end
    // Read data is latched in the setup cycle; unmapped reads return zero.
    if (apbSetupRead) begin
      state_next.readBack = '0;
      case (paddr)
        fifo_pkg::CONFIG_OFFSET: begin
          state_next.readBack[fifo_pkg::CFG_WCODE_LSB +: fifo_pkg::CODE_W] =
            state_reg.writeWidthCode;
          state_next.readBack[fifo_pkg::CFG_RCODE_LSB +: fifo_pkg::CODE_W] =
            state_reg.readWidthCode;
          state_next.readBack[fifo_pkg::CFG_WEN_HIGH] = state_reg.wenHigh;
          state_next.readBack[fifo_pkg::CFG_REN_HIGH] = state_reg.renHigh;
          state_next.readBack[fifo_pkg::CFG_PIPE] =
            state_reg.readPipelineSelect;
          state_next.readBack[fifo_pkg::CFG_EMPTY_STOP] = state_reg.emptyStop;
          state_next.readBack[fifo_pkg::CFG_FULL_STOP] = state_reg.fullStop;
        end
        fifo_pkg::THRESH_OFFSET: begin
          state_next.readBack[fifo_pkg::THR_AF_LSB +: fifo_pkg::ADDR_W] =
            state_reg.almostFullThreshold;
          state_next.readBack[fifo_pkg::THR_AE_LSB +: fifo_pkg::ADDR_W] =
            state_reg.almostEmptyThreshold;
        end
        fifo_pkg::STATUS_OFFSET: state_next.readBack = statusWord;
        default:                 state_next.readBack = '0;
      endcase
    end
  end

  // Reset clears every field, stored bits included; read enable resets high and the thresholds load their reset values.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_reg                      <= '0;
      state_reg.renHigh              <= 1'b1;
      state_reg.almostFullThreshold  <= fifo_pkg::AF_RESET;
      state_reg.almostEmptyThreshold <= fifo_pkg::AE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  property p_resetFlags;
    !fifoResetN |-> (!full && !almostFullFlag && empty && almostEmptyFlag
                     && (readData == '0));
  endproperty
  a_resetFlags: assert property (p_resetFlags)
    else $error("Clear does not force flags and read data.");

  property p_clearCounters;
    !fifoResetN |=> (state_reg.wrPtr == '0) && (state_reg.rdPtr == '0);
  endproperty
  a_clearCounters: assert property (p_clearCounters)
    else $error("Counters not cleared.");

  // A read from two edges earlier may already reach the write side, so
  // only a read without one two edges before is held to the full delay.
  property p_fullHold;
    (full && readAccept && !$past(readAccept, 2)) ##1 fifoResetN |-> full;
  endproperty
  a_fullHold: assert property (p_fullHold)
    else $error("Full fell one edge after a read.");

  // Same reasoning on the read side: earlier writes arrive on their own.
  property p_emptyHold;
    (empty && writeAccept && fifoResetN && !$past(writeAccept, 2)) ##1
      fifoResetN |-> empty;
  endproperty
  a_emptyHold: assert property (p_emptyHold)
    else $error("Empty fell one edge after a write.");

  property p_writeStop;
    (full && state_reg.fullStop && fifoResetN) |=> $stable(state_reg.wrPtr);
  endproperty
  a_writeStop: assert property (p_writeStop)
    else $error("Write counter moved while stopped at full.");

  property p_readStop;
    (empty && state_reg.emptyStop && fifoResetN) |=> $stable(state_reg.rdPtr);
  endproperty
  a_readStop: assert property (p_readStop)
    else $error("Read counter moved while stopped at empty.");

  property p_writeStep;
    (writeAccept && fifoResetN) |=>
      state_reg.wrPtr == $past(state_reg.wrPtr) + $past(writeStep);
  endproperty
  a_writeStep: assert property (p_writeStep)
    else $error("Write counter did not advance by one word.");

  property p_flowData;
    (readAccept && !state_reg.readPipelineSelect) ##1
      (fifoResetN && !state_reg.readPipelineSelect)
      |-> readData == $past(readWordNow);
  endproperty
  a_flowData: assert property (p_flowData)
    else $error("Flow-through data wrong after a read.");

  property p_pipeData;
    (readAccept && state_reg.readPipelineSelect) ##1
      (fifoResetN && !readBlockSelectN && state_reg.readPipelineSelect) ##1
      (fifoResetN && state_reg.readPipelineSelect)
      |-> readData == $past(readWordNow, 2);
  endproperty
  a_pipeData: assert property (p_pipeData)
    else $error("Pipelined data wrong two edges after a read.");

  property p_holdDeselected;
    (readBlockSelectN && fifoResetN && !readAccept) ##1
      (fifoResetN && $stable(state_reg.readPipelineSelect))
      |-> $stable(readData);
  endproperty
  a_holdDeselected: assert property (p_holdDeselected)
    else $error("Read data changed while the read port was deselected.");

  c_fullSeen:   cover property (writeAccept ##1 full);
  c_emptyClear: cover property (empty ##1 !empty);
  c_pipeRead:   cover property (readAccept && state_reg.readPipelineSelect);
  c_almostFull: cover property ($rose(almostFullFlag));

endmodule

// >>> fifo_user.sv
// Write-side and read-side user logic that drives the FIFO data ports.
`timescale 1ns/1ps
module fifo_user (
  input  wire logic        clock,
  input  wire logic        wrReq,
  input  wire logic        rdReq,
  input  wire logic        wrPolHigh,
  input  wire logic        rdPolHigh,
  input  wire logic [2:0]  wrCode,
  input  wire logic [17:0] wrWord,
  output logic             writeEnable,
  output logic             readEnable,
  output logic [17:0]      writeData
);
  logic [17:0] mask;
  logic        idleReg = 1'b0;

  // Between writes the data lines toggle so that stale data is never trusted.
  always_ff @(posedge clock) begin
    idleReg <= ~idleReg;
  end

  // Unused high-order data bits are grounded for narrow write widths.
  always_comb begin
    case (wrCode)
      3'h0:    mask = 18'h00001;
      3'h1:    mask = 18'h00003;
      3'h2:    mask = 18'h0000F;
      3'h3:    mask = 18'h001FF;
      default: mask = 18'h3FFFF;
    endcase
    writeData = (wrReq ? wrWord : {18{idleReg}}) & mask;
    writeEnable = wrPolHigh ? wrReq : ~wrReq;
    readEnable = rdPolHigh ? rdReq : ~rdReq;
  end
endmodule

// >>> test_dual_clock_embedded_fifo.sv
// Self-checking bench with a queue model of the embedded FIFO.
`timescale 1ns/1ps
module test_dual_clock_embedded_fifo;
  logic clock = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, fifoResetN = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'hAB04F05B, r;
  logic writeBlockSelectN = 1'b0, readBlockSelectN = 1'b0;
  logic writeEnable, readEnable, full, empty, almostFullFlag;
  logic almostEmptyFlag, er, sF, sE, sAF, sAE;
  logic wrReq = 1'b0, rdReq = 1'b0, wrPolHigh = 1'b0, pipe, full_stop, empty_stop;
  logic rdPolHigh = 1'b1;
  logic [17:0] wrWord = 18'h0, writeData, readData, st1, st2, expRd;
  logic [2:0] wc = 3'h0;
  logic [17:0] mq[$];
  int error_cnt = 0, n_checks = 0, stp, af, ae;

  // The clock runs at 10 MHz.
  always #50 clock = ~clock;

  dual_clock_embedded_fifo uut (.clock(clock), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fifoResetN(fifoResetN), .writeBlockSelectN(writeBlockSelectN),
    .writeEnable(writeEnable), .writeData(writeData),
    .readBlockSelectN(readBlockSelectN), .readEnable(readEnable),
    .readData(readData), .full(full), .empty(empty),
    .almostFullFlag(almostFullFlag), .almostEmptyFlag(almostEmptyFlag));

  fifo_user user (.clock(clock), .wrReq(wrReq), .rdReq(rdReq),
    .wrPolHigh(wrPolHigh), .rdPolHigh(rdPolHigh),
    .wrCode(wc), .wrWord(wrWord),
    .writeEnable(writeEnable), .readEnable(readEnable),
    .writeData(writeData));

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function logic [17:0] wmask(input logic [2:0] c);
    return (c == 3'h4) ? 18'h3FFFF : (c == 3'h3) ? 18'h001FF
      : 18'((32'h1 << (32'h1 << c)) - 1);
  endfunction

  task close_out();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task check(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    n_checks++;
    if (seen !== ex) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, seen);
    end
  endtask

  // One APB transfer; the request is held until pready is seen high.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    // A back-to-back call lets one edge pass, so psel is not set twice.
    if (psel === 1'b1) @(posedge clock);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge clock);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      error_cnt++;
      close_out();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task cfg(input logic [31:0] v);
    apb(1'b1, 8'h00, v);
    wc <= v[2:0]; wrPolHigh <= v[6];
    rdPolHigh <= v[7];
    pipe = v[8]; empty_stop = v[9]; full_stop = v[10];
    stp = 1 << v[2:0];
  endtask

  // One cycle of traffic; the model advances the read stages at the edge.
  task xfer(input logic w, input logic rq, input logic [17:0] d);
    wrReq <= w; rdReq <= rq; wrWord <= d;
    #50;
    sF = full; sE = empty; sAF = almostFullFlag; sAE = almostEmptyFlag;
    check("readData", 32'(readData), 32'(expRd));
    if (w && !writeBlockSelectN && !(full_stop && mq.size() * stp >= 4096))
      mq.push_back(d & wmask(wc));
    if (!readBlockSelectN) st2 = st1;
    if (rq && !readBlockSelectN && mq.size() > 0) st1 = mq.pop_front();
    @(posedge clock);
    expRd = pipe ? st2 : st1;
  endtask

  // Flags are compared once the pointer synchronisers have settled.
  task flags(input string nm);
    int b;
    repeat (3) xfer(1'b0, 1'b0, 18'h0);
    b = mq.size() * stp;
    check("full", 32'(sF), 32'(b > 4096 - stp));
    check("empty", 32'(sE), 32'(b < stp));
    check("almostFull", 32'(sAF), 32'(b >= af));
    check("almostEmpty", 32'(sAE), 32'(b <= ae));
    $display("test %s done", nm);
  endtask

  task fclear();
    fifoResetN <= 1'b0;
    repeat (3) @(posedge clock);
    #50;
    check("clear", 32'({full, empty, almostFullFlag, almostEmptyFlag,
      readData}), 32'h00140000);
    @(posedge clock);
    fifoResetN <= 1'b1;
    mq.delete();
    st1 = 18'h0; st2 = 18'h0; expRd = 18'h0;
  endtask

  // A hung run is cut short and counted as a mismatch.
  initial begin
    #6000000;
    error_cnt++;
    close_out();
  end

  initial begin
    st1 = 18'h0; st2 = 18'h0; expRd = 18'h0; pipe = 0; full_stop = 0; empty_stop = 0;
    stp = 1; af = 4095; ae = 0;
    #400;
    check("reset", 32'({full, empty, almostFullFlag, almostEmptyFlag,
      readData}), 32'h00140000);
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    apb(1'b0, 8'h00, 32'h0);
    check("CONFIG", rd, 32'h00000080);
    apb(1'b0, 8'h04, 32'h0);
    check("THRESH", rd, 32'h00000FFF);
    apb(1'b0, 8'h0C, 32'h0);
    check("unmapped", {31'h0, er}, 32'h1);
    apb(1'b1, 8'h04, 32'h00200040);
    af = 64; ae = 32;
    cfg(32'h000006A4);
    xfer(1'b1, 1'b0, rnd());
    xfer(1'b0, 1'b0, 18'h0);
    xfer(1'b0, 1'b0, 18'h0);
    check("emptyHold", 32'(sE), 32'h1);
    xfer(1'b0, 1'b0, 18'h0);
    check("emptyFall", 32'(sE), 32'h0);
    xfer(1'b0, 1'b1, 18'h0);
    flags("first word");
    repeat (300) begin
      r = rnd();
      xfer(r[0] && mq.size() < 250, r[1] && mq.size() >= 3, r[31:14]);
    end
    flags("random traffic");
    for (int i = 0; i < 300 && mq.size() < 256; i++) xfer(1'b1, 1'b0, rnd());
    xfer(1'b1, 1'b0, 18'h3FFFF);
    flags("fill and stop");
    xfer(1'b0, 1'b1, 18'h0);
    xfer(1'b0, 1'b0, 18'h0);
    xfer(1'b0, 1'b0, 18'h0);
    check("fullHold", 32'(sF), 32'h1);
    xfer(1'b0, 1'b0, 18'h0);
    check("fullFall", 32'(sF), 32'h0);
    for (int i = 0; i < 300 && mq.size() > 0; i++) xfer(1'b0, 1'b1, 18'h0);
    xfer(1'b0, 1'b1, 18'h0);
    flags("drain and stop");
    cfg(32'h000007E4);
    repeat (3) xfer(1'b1, 1'b0, rnd());
    flags("active high write");
    readBlockSelectN <= 1'b1; writeBlockSelectN <= 1'b1;
    xfer(1'b1, 1'b1, rnd());
    readBlockSelectN <= 1'b0; writeBlockSelectN <= 1'b0;
    repeat (3) xfer(1'b0, 1'b1, 18'h0);
    flags("pipelined read");
    for (int c = 0; c < 5; c++) begin
      fclear();
      cfg(32'h00000680 | 32'(c) | (32'(c) << 3));
      xfer(1'b1, 1'b0, rnd());
      flags("width code");
      xfer(1'b0, 1'b1, 18'h0);
      xfer(1'b0, 1'b0, 18'h0);
    end
    fclear();
    cfg(32'h00000611);
    xfer(1'b1, 1'b0, 18'h1);
    repeat (3) xfer(1'b0, 1'b0, 18'h0);
    check("halfWord", 32'(sE), 32'h1);
    xfer(1'b1, 1'b0, 18'h2);
    repeat (3) xfer(1'b0, 1'b0, 18'h0);
    check("wholeWord", 32'(sE), 32'h0);
    check("mixedAE", 32'(sAE), 32'h1);
    $display("test mixed widths done");
    close_out();
  end
endmodule
